// file: tld_pkg.sv
// Package: register map, field layout, limits and timing for the torque load detector
package tld_pkg;
    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_SELECT = 8'h00;
    localparam logic [7:0] OFF_LEVEL  = 8'h04;
    localparam logic [7:0] OFF_DELAY  = 8'h08;
    localparam logic [7:0] OFF_RELAY  = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_ST = 8'h14;
    localparam logic [7:0] OFF_IRQ_MK = 8'h18;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int SEL_W       = 4;
    localparam int FN_W        = 5;
    localparam int RLY_B_LSB   = 8;
    localparam int FLT_CLR_BIT = 8;
    localparam int ST_DET      = 0;
    localparam int ST_ALARM    = 1;
    localparam int ST_FAULT    = 2;
    localparam int ST_COND     = 3;
    localparam int ST_AT_SPEED = 4;
    localparam int ST_RLY_A    = 5;
    localparam int ST_RLY_B    = 6;
    localparam int IRQ_W       = 2;
    localparam int IRQ_DET     = 0;
    localparam int IRQ_FAULT   = 1;

    // ---------------------------------------------------------------
    // Selector codes, limits and reset values
    // ---------------------------------------------------------------
    localparam logic [3:0] SEL_OFF       = 4'h0;
    localparam logic [3:0] SEL_UNDER_MIN = 4'h5;
    localparam logic [3:0] SEL_MAX       = 4'h8;
    localparam logic [4:0] FN_DET_NO     = 5'h06;
    localparam logic [4:0] FN_DET_NC     = 5'h07;
    localparam logic [7:0] LEVEL_MIN     = 8'h1E; // 30 %
    localparam logic [7:0] LEVEL_MAX     = 8'hC8; // 200 %
    localparam logic [7:0] LEVEL_RST     = 8'hA0; // 160 %
    localparam logic [6:0] DELAY_MAX     = 7'h64; // 10.0 s in tenths
    localparam logic [6:0] DELAY_RST     = 7'h01; // 0.1 s

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TENTH_NS      = 100000000; // delay step, 0.1 s
    localparam int BLINK_NS      = 250000000; // alarm blink half period
    localparam int TENTH_CYC     = TENTH_NS / CLK_PERIOD_NS;
    localparam int BLINK_CYC     = BLINK_NS / CLK_PERIOD_NS;
endpackage

// file: tld_torque_load_detector.sv
// Torque load detector: APB registers, qualified level compare, delay timer, alarm/fault/relay outputs
`timescale 1ns/1ps
`default_nettype none
module tld_torque_load_detector
    import tld_pkg::*;
#(
    parameter int TENTH_CYCLES = TENTH_CYC,
    parameter int BLINK_CYCLES = BLINK_CYC,
    parameter int FREQ_W       = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    input  wire logic [7:0]        output_current_pct,
    input  wire logic              drive_running,
    input  wire logic              drive_stopping,
    input  wire logic              dc_braking,
    input  wire logic [FREQ_W-1:0] freq_reference,
    input  wire logic [FREQ_W-1:0] output_frequency,
    output logic                   overload_three_indication,
    output logic                   overload_three_blink,
    output logic                   overload_three_fault,
    output logic                   coast_to_stop,
    output logic                   form_c_relay_terminal,
    output logic                   normally_open_relay_terminal,
    output logic                   irq
);
    localparam int PW = $clog2(TENTH_CYCLES + 1);
    localparam int BW = $clog2(BLINK_CYCLES + 1);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [SEL_W-1:0] torque_detect_select_r;
    logic [7:0]       torque_detect_level_r;
    logic [6:0]       torque_detect_delay_r;
    logic [FN_W-1:0]  relay_a_function_select_r;
    logic [FN_W-1:0]  relay_b_function_select_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [PW-1:0]    pre_r;
    logic [6:0]       tenths_r;
    logic             det_r;
    logic             fault_r;
    logic [BW-1:0]    blink_cnt_r;
    logic             blink_r;
    logic             relay_a_r;
    logic             relay_b_r;

    logic             wr_en;
    logic             rd_setup;
    logic             hit;
    logic             at_speed;
    logic             qual;
    logic             under_mode;
    logic             stop_mode;
    logic             cmp;
    logic             cond;
    logic [IRQ_W-1:0] irq_set;
    logic [31:0]      rd_nxt;
    logic             det_nxt;

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    // Zero wait state; read data captured in setup so prdata is a flop
    assign pready   = 1'b1;
    assign hit      = (paddr == OFF_SELECT) || (paddr == OFF_LEVEL) || (paddr == OFF_DELAY)
                   || (paddr == OFF_RELAY) || (paddr == OFF_STATUS) || (paddr == OFF_IRQ_ST)
                   || (paddr == OFF_IRQ_MK);
    assign pslverr  = psel && penable && !hit;
    assign wr_en    = psel && penable && pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite;

    // Selector; values above the table are refused and keep the old mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            torque_detect_select_r <= SEL_OFF;
        end else if (wr_en && paddr == OFF_SELECT && pwdata[SEL_W-1:0] <= SEL_MAX) begin
            torque_detect_select_r <= pwdata[SEL_W-1:0];
        end
    end

    // Level, clamped into its legal range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            torque_detect_level_r <= LEVEL_RST;
        end else if (wr_en && paddr == OFF_LEVEL) begin
            if (pwdata[7:0] < LEVEL_MIN) begin
                torque_detect_level_r <= LEVEL_MIN;
            end else if (pwdata[7:0] > LEVEL_MAX) begin
                torque_detect_level_r <= LEVEL_MAX;
            end else begin
                torque_detect_level_r <= pwdata[7:0];
            end
        end
    end

    // Delay in tenths of a second, clamped at 10.0 s
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            torque_detect_delay_r <= DELAY_RST;
        end else if (wr_en && paddr == OFF_DELAY) begin
            if (pwdata[7:0] > {1'b0, DELAY_MAX}) begin
                torque_detect_delay_r <= DELAY_MAX;
            end else begin
                torque_detect_delay_r <= pwdata[6:0];
            end
        end
    end

    // Relay function selectors and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_a_function_select_r <= '0;
            relay_b_function_select_r <= '0;
            irq_mask_r                <= '0;
        end else if (wr_en && paddr == OFF_RELAY) begin
            relay_a_function_select_r <= pwdata[FN_W-1:0];
            relay_b_function_select_r <= pwdata[RLY_B_LSB +: FN_W];
        end else if (wr_en && paddr == OFF_IRQ_MK) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
        end
    end

    // Read mux
    always_comb begin
        rd_nxt = '0;
        case (paddr)
            OFF_SELECT: rd_nxt[SEL_W-1:0] = torque_detect_select_r;
            OFF_LEVEL:  rd_nxt[7:0] = torque_detect_level_r;
            OFF_DELAY:  rd_nxt[6:0] = torque_detect_delay_r;
            OFF_RELAY: begin
                rd_nxt[FN_W-1:0]             = relay_a_function_select_r;
                rd_nxt[RLY_B_LSB +: FN_W]    = relay_b_function_select_r;
            end
            OFF_STATUS: begin
                rd_nxt[ST_DET]      = det_r;
                rd_nxt[ST_ALARM]    = overload_three_indication;
                rd_nxt[ST_FAULT]    = fault_r;
                rd_nxt[ST_COND]     = cond;
                rd_nxt[ST_AT_SPEED] = at_speed;
                rd_nxt[ST_RLY_A]    = relay_a_r;
                rd_nxt[ST_RLY_B]    = relay_b_r;
            end
            OFF_IRQ_ST: rd_nxt[IRQ_W-1:0] = irq_stat_r;
            OFF_IRQ_MK: rd_nxt[IRQ_W-1:0] = irq_mask_r;
            default:    rd_nxt = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= rd_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Condition qualification
    // ---------------------------------------------------------------
    // Core signals share pclk, so no synchroniser is needed here
    assign at_speed   = (freq_reference == output_frequency);
    assign under_mode = (torque_detect_select_r >= SEL_UNDER_MIN);
    assign stop_mode  = (torque_detect_select_r[1:0] == 2'b11) || (torque_detect_select_r[1:0] == 2'b00);
    assign cmp        = under_mode ? (output_current_pct < torque_detect_level_r)
                                   : (output_current_pct >= torque_detect_level_r);
    assign qual       = torque_detect_select_r[0] ? (drive_running && at_speed)
                                                 : (drive_running && !drive_stopping && !dc_braking);
    assign cond       = (torque_detect_select_r != SEL_OFF) && qual && cmp;

    // ---------------------------------------------------------------
    // Persistence timer
    // ---------------------------------------------------------------
    // Any dropout restarts the whole count, so glitches never accumulate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r    <= '0;
            tenths_r <= '0;
        end else if (!cond) begin
            pre_r    <= '0;
            tenths_r <= '0;
        end else if (tenths_r < torque_detect_delay_r) begin
            if (pre_r == PW'(TENTH_CYCLES - 1)) begin
                pre_r    <= '0;
                tenths_r <= tenths_r + 7'd1;
            end else begin
                pre_r <= pre_r + PW'(1);
            end
        end
    end

    assign det_nxt = cond && (tenths_r >= torque_detect_delay_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_r <= 1'b0;
        end else begin
            det_r <= det_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Fault latch, alarm blink, relays
    // ---------------------------------------------------------------
    // Fault holds after the motor coasts; only software clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_r <= 1'b0;
        end else if (det_r && stop_mode) begin
            fault_r <= 1'b1;
        end else if (wr_en && paddr == OFF_SELECT && pwdata[FLT_CLR_BIT]) begin
            fault_r <= 1'b0;
        end
    end

    assign overload_three_fault      = fault_r;
    assign coast_to_stop             = fault_r;
    assign overload_three_indication = det_r && !stop_mode;
    assign overload_three_blink      = overload_three_indication && blink_r;

    // Blink phase restarts each detection so the first phase is lit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b1;
        end else if (!overload_three_indication) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b1;
        end else if (blink_cnt_r == BW'(BLINK_CYCLES - 1)) begin
            blink_cnt_r <= '0;
            blink_r     <= !blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + BW'(1);
        end
    end

    // Relay closed is 1; codes other than 6 and 7 belong to other functions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_a_r <= 1'b0;
            relay_b_r <= 1'b0;
        end else begin
            relay_a_r <= (relay_a_function_select_r == FN_DET_NO) ? det_nxt
                       : (relay_a_function_select_r == FN_DET_NC) ? !det_nxt : 1'b0;
            relay_b_r <= (relay_b_function_select_r == FN_DET_NO) ? det_nxt
                       : (relay_b_function_select_r == FN_DET_NC) ? !det_nxt : 1'b0;
        end
    end

    assign form_c_relay_terminal        = relay_a_r;
    assign normally_open_relay_terminal = relay_b_r;

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    // Set wins over a same-cycle write-one clear
    assign irq_set[IRQ_DET]   = det_nxt && !det_r;
    assign irq_set[IRQ_FAULT] = det_r && stop_mode && !fault_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
        end else if (wr_en && paddr == OFF_IRQ_ST) begin
            irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    off_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        torque_detect_select_r == SEL_OFF |-> !det_nxt && !overload_three_indication)
        else $error("detection active while disabled");
    over_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(det_r) && !under_mode |-> $past(output_current_pct >= torque_detect_level_r))
        else $error("overtorque without current at level");
    under_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(det_r) && under_mode |-> $past(output_current_pct < torque_detect_level_r))
        else $error("undertorque without current below level");
    speed_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(det_r) && torque_detect_select_r[0] |-> $past(freq_reference == output_frequency))
        else $error("at-speed mode detected off speed");
    delay_held_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(det_r) && $stable(torque_detect_delay_r) |-> $past(tenths_r) >= torque_detect_delay_r)
        else $error("detection before delay elapsed");
    dropout_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cond |=> !det_r && tenths_r == 7'd0 && !overload_three_indication)
        else $error("timer or alarm kept after dropout");
    fault_coast_a: assert property (@(posedge pclk) disable iff (!presetn)
        det_r && stop_mode |=> fault_r && coast_to_stop)
        else $error("stopping mode did not latch fault");
    alarm_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        det_r && !stop_mode && !fault_r |-> overload_three_indication && !coast_to_stop)
        else $error("continuing mode missing alarm or stopped");
    relay_sense_a: assert property (@(posedge pclk) disable iff (!presetn)
        relay_b_function_select_r == FN_DET_NC && $stable(relay_b_function_select_r)
        |-> normally_open_relay_terminal == !det_r)
        else $error("normally-closed relay sense wrong");
    relay_direct_a: assert property (@(posedge pclk) disable iff (!presetn)
        relay_a_function_select_r == FN_DET_NO && $stable(relay_a_function_select_r)
        |-> form_c_relay_terminal == det_r)
        else $error("normally-open relay sense wrong");
    level_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        torque_detect_level_r >= LEVEL_MIN && torque_detect_level_r <= LEVEL_MAX)
        else $error("level out of range");
endmodule
`default_nettype wire

// file: tld_drive_core_model.sv
// Drive core stand-in: measured current, run state and frequencies for the detector
`timescale 1ns/1ps
`default_nettype none
module tld_drive_core_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  cur_cmd,
    input  wire logic        run_cmd,
    input  wire logic        stop_cmd,
    input  wire logic        brake_cmd,
    input  wire logic        speed_ok,
    output logic [7:0]       output_current_pct,
    output logic             drive_running,
    output logic             drive_stopping,
    output logic             dc_braking,
    output logic [15:0]      freq_reference,
    output logic [15:0]      output_frequency
);
    // -----------------------------------------------------------
    // Measurement path
    // -----------------------------------------------------------
    // One sample of latency, as a real current measurement would add
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_current_pct <= 8'h00;
            drive_running      <= 1'b0;
            drive_stopping     <= 1'b0;
            dc_braking         <= 1'b0;
            output_frequency   <= 16'h0000;
        end else begin
            output_current_pct <= cur_cmd;
            drive_running      <= run_cmd;
            drive_stopping     <= stop_cmd;
            dc_braking         <= brake_cmd;
            output_frequency   <= speed_ok ? 16'h0258 : 16'h0257; // One step short while ramping
        end
    end
    // Fixed reference keeps the equality test meaningful
    assign freq_reference = 16'h0258;
endmodule
`default_nettype wire

// file: tld_torque_load_detector_tb.sv
// Self-checking bench for the torque load detector, driven over APB
`timescale 1ns/1ps
`default_nettype none
module tld_torque_load_detector_tb;
    import tld_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire logic   pready, pslverr;
    wire logic [31:0] prdata;
    logic [7:0]  cur_cmd;
    logic        run_cmd, stop_cmd, brake_cmd, speed_ok;
    wire logic [7:0]  cur;
    wire logic        run, stopping, braking;
    wire logic [15:0] fref, fout;
    wire logic        ind, blink, fault, coast, rly_a, rly_b, irq;
    logic [31:0] rd;
    logic        err, und, stp;
    logic [6:0]  pv;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc_cnt = 0;
    int          ones;

    tld_drive_core_model u_tld_drive_core_model (.pclk(pclk), .presetn(presetn), .cur_cmd(cur_cmd),
        .run_cmd(run_cmd), .stop_cmd(stop_cmd), .brake_cmd(brake_cmd), .speed_ok(speed_ok),
        .output_current_pct(cur), .drive_running(run), .drive_stopping(stopping), .dc_braking(braking),
        .freq_reference(fref), .output_frequency(fout));

    // Short time base so the delay and blink counts stay small
    tld_torque_load_detector #(.TENTH_CYCLES(10), .BLINK_CYCLES(4)) u_tld_torque_load_detector (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .output_current_pct(cur),
        .drive_running(run), .drive_stopping(stopping), .dc_braking(braking), .freq_reference(fref),
        .output_frequency(fout), .overload_three_indication(ind), .overload_three_blink(blink),
        .overload_three_fault(fault), .coast_to_stop(coast), .form_c_relay_terminal(rly_a),
        .normally_open_relay_terminal(rly_b), .irq(irq));

    // -----------------------------------------------------------
    // Clock and hang guard
    // -----------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Whole run needs about four hundred cycles; fifty times that means a hang
    always @(posedge pclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Entered just after a rising edge; request held until pready is seen high
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, rd, exp);
    endtask
    // Samples the outputs mid-cycle, then returns on a rising edge
    task automatic look(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        pv = {irq, rly_b, rly_a, coast, fault, blink, ind};
        @(posedge pclk);
    endtask
    task automatic final_report;
        $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // -----------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        cur_cmd = 8'h00; run_cmd = 1'b0; stop_cmd = 1'b0; brake_cmd = 1'b0; speed_ok = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("select rst", OFF_SELECT, 32'h0);
        rdc("level rst", OFF_LEVEL, 32'hA0);
        rdc("delay rst", OFF_DELAY, 32'h1);
        rdc("relay rst", OFF_RELAY, 32'h0);
        rdc("unmapped", 8'h1C, 32'h0);
        chk("unmapped err", err, 1'b1);
        wr(OFF_LEVEL, 32'h0A);
        rdc("level low clamp", OFF_LEVEL, 32'h1E);
        wr(OFF_LEVEL, 32'hFA);
        rdc("level high clamp", OFF_LEVEL, 32'hC8);
        wr(OFF_DELAY, 32'hC8);
        rdc("delay clamp", OFF_DELAY, 32'h64);
        wr(OFF_SELECT, 32'h9);
        rdc("select bad", OFF_SELECT, 32'h0);
        // Detection off: heavy current while running changes nothing
        cur_cmd <= 8'hFA;
        run_cmd <= 1'b1;
        speed_ok <= 1'b1;
        look(30);
        chk("disabled", pv, 7'h00);
        $display("Test registers and disable done");
        // Quiet the load first so the first mode write cannot detect at once
        cur_cmd <= 8'h00;
        speed_ok <= 1'b0;
        // Level at the boundary value, no delay, relay A normally open, B normally closed
        wr(OFF_LEVEL, 32'h64);
        wr(OFF_DELAY, 32'h0);
        wr(OFF_RELAY, 32'h0706);
        wr(OFF_IRQ_MK, 32'h3);
        for (int s = 1; s <= 8; s++) begin
            und = (s >= 5);
            stp = ((s - 1) % 4) >= 2;
            wr(OFF_SELECT, 32'(s));
            // Even modes stop or brake, odd modes miss set frequency
            cur_cmd <= und ? 8'h63 : 8'h64;
            speed_ok <= 1'b0;
            stop_cmd <= (s % 4 == 2);
            brake_cmd <= (s % 4 == 0);
            look(4);
            chk("held off", pv, 7'h20);
            // Even modes must detect even off set frequency
            speed_ok <= (s % 2 == 1);
            stop_cmd <= 1'b0;
            brake_cmd <= 1'b0;
            look(4);
            chk("detected", pv, {3'b101, stp, stp, !stp, !stp});
            cur_cmd <= und ? 8'h64 : 8'h63;
            look(4);
            chk("dropped", pv, {3'b110, stp, stp, 2'b00});
            wr(OFF_SELECT, 32'h100 | 32'(s));
            wr(OFF_IRQ_ST, 32'h3);
            look(1);
            chk("cleared", pv, 7'h20);
        end
        $display("Test mode table done");
        // Delay of two tenths, with a dropout that must restart the count
        wr(OFF_DELAY, 32'h2);
        wr(OFF_SELECT, 32'h2);
        cur_cmd <= 8'h96;
        look(14);
        chk("early", pv[0], 1'b0);
        cur_cmd <= 8'h32;
        look(1);
        cur_cmd <= 8'h96;
        look(14);
        chk("restart", pv[0], 1'b0);
        look(10);
        chk("late", pv[0], 1'b1);
        $display("Test delay done");
        // Eight cycles of a four-cycle half period light exactly four
        ones = 0;
        repeat (8) begin
            @(negedge pclk);
            ones += int'(blink === 1'b1);
        end
        @(posedge pclk);
        chk("blink", 32'(ones), 32'h4);
        rdc("status", OFF_STATUS, 32'h2B);
        wr(OFF_IRQ_MK, 32'h0);
        look(0);
        chk("irq masked", pv[6], 1'b0);
        rdc("irq stat", OFF_IRQ_ST, 32'h1);
        wr(OFF_IRQ_MK, 32'h1);
        look(0);
        chk("irq unmasked", pv[6], 1'b1);
        wr(OFF_IRQ_ST, 32'h1);
        look(0);
        chk("irq cleared", pv[6], 1'b0);
        $display("Test blink and interrupt done");
        final_report();
    end
endmodule
`default_nettype wire
